// >>> src/ceil_core.sv
// ceil_core: error detection, parity generation and sticky interrupt lines
// of a second-level cache controller.
// assumes the cache pipeline presents one tag read/write and one data
// read/write qualifier per cycle, tagged with the owning operation.
//
// Functional notes
// - each individual interrupt output stays high once set, until its irq_clear bit is written
// - combined interrupt is the OR of all nine lines
// - separate lines for next-level, RAM read/write and parity errors
// - event counter line sets on overflow or increment per configured condition
// - one parity bit per byte of data RAM write data
// - one tag parity bit, routed by integration to every tag RAM
// - one data RAM fault input and eight tag RAM fault inputs
// - slave read tag error raises tag-read line and returns SLVERR
// - slave read hit data error raises data-read line and returns SLVERR
// - store buffer tag read error raises tag-read line, cache not written
// - store buffer data write fault raises data-write line
// - allocation eviction tag error raises tag-read line, eviction masked, continue
// - allocation data read error: RAM fault masks eviction, parity passes data
// - allocation tag write fault raises tag-write line
// - allocation data write fault raises data-write line
// - clean tag read error raises tag-read line and cancels clean
// - clean data read error: RAM fault masks eviction, parity passes data
// - invalidate tag read error raises tag-read line and cancels invalidate
// - invalidate valid-info write fault raises tag-write line
// - eviction or drain write error response only raises decerr/slverr line
// - linefill error response blocks data load and tag update, raises line
`timescale 1ns/1ns
`default_nettype none

module ceil_core
(
  // clock and reset
  input  wire logic                                 sys_clk,
  input  wire logic                                 arst_n,
  input  wire logic                                 clk_en,
  // operation context
  input  wire ceil_pkg::ceil_op_t                   op_kind,
  // tag RAM access
  input  wire logic                                 tag_rd_vld,
  input  wire logic                                 tag_rd_parity_err,
  input  wire logic                                 tag_wr_vld,
  input  wire logic [ceil_pkg::TAG_WAYS-1:0]        tag_array_fault_in,
  input  wire logic [ceil_pkg::TAG_W-1:0]           tag_wr_data,
  // data RAM access
  input  wire logic                                 data_rd_vld,
  input  wire logic                                 data_rd_parity_err,
  input  wire logic                                 data_wr_vld,
  input  wire logic                                 data_array_fault_in,
  input  wire logic [ceil_pkg::DATA_W-1:0]          data_wr_data,
  // next-level write and read responses
  input  wire logic                                 nl_bresp_vld,
  input  wire logic [1:0]                           nl_bresp,
  input  wire logic                                 nl_fill_vld,
  input  wire logic [1:0]                           nl_fill_resp,
  // event counters
  input  wire logic                                 evt_cnt_overflow,
  input  wire logic                                 evt_cnt_increment,
  input  wire logic                                 evt_cnt_irq_on_inc,
  // software clear, one bit per line
  input  wire logic [ceil_pkg::IRQ_NUM-1:0]         irq_clear,
  // RAM write parity
  output logic [ceil_pkg::DATA_BYTES-1:0]           data_wr_parity,
  output logic                                      tag_wr_parity,
  // pipeline steering
  output logic                                      slave_read_response_err,
  output logic [1:0]                                slave_read_response,
  output logic                                      cache_write_block,
  output logic                                      evict_mask,
  output logic                                      maint_cancel,
  output logic                                      fill_discard,
  // interrupt lines
  output logic                                      next_level_decode_err_irq,
  output logic                                      next_level_slave_err_irq,
  output logic                                      data_ram_read_err_irq,
  output logic                                      tag_ram_read_err_irq,
  output logic                                      data_ram_write_err_irq,
  output logic                                      tag_ram_write_err_irq,
  output logic                                      data_read_parity_irq,
  output logic                                      tag_read_parity_irq,
  output logic                                      event_counter_irq,
  output logic                                      combined_irq
);

  // ----------------------------------------------------------------
  // error qualification
  // ----------------------------------------------------------------
  logic                           tag_fault;
  logic                           tag_rd_ram_err;
  logic                           tag_rd_par_err;
  logic                           tag_wr_ram_err;
  logic                           data_rd_ram_err;
  logic                           data_rd_par_err;
  logic                           data_wr_ram_err;
  logic                           slave_rd;
  logic                           evicting;
  logic                           maint;
  logic                           fill_err;
  logic                           wresp_err;
  logic                           tag_rd_any;
  logic [ceil_pkg::IRQ_NUM-1:0]   irq_set;
  logic [ceil_pkg::IRQ_NUM-1:0]   irq;
  logic [ceil_pkg::IRQ_NUM-1:0]   next_irq;
  logic [ceil_pkg::IRQ_NUM-1:0]   set_and_clear;

  // any way may flag; only one way is accessed per cycle
  assign tag_fault       = |tag_array_fault_in;
  assign tag_rd_ram_err  = tag_rd_vld & tag_fault;
  assign tag_rd_par_err  = tag_rd_vld & tag_rd_parity_err;
  assign tag_wr_ram_err  = tag_wr_vld & tag_fault;
  assign data_rd_ram_err = data_rd_vld & data_array_fault_in;
  assign data_rd_par_err = data_rd_vld & data_rd_parity_err;
  assign data_wr_ram_err = data_wr_vld & data_array_fault_in;
  assign tag_rd_any      = tag_rd_ram_err | tag_rd_par_err;
  assign slave_rd        = (op_kind == ceil_pkg::CEIL_OP_SLAVE_READ);
  assign evicting        = (op_kind == ceil_pkg::CEIL_OP_ALLOC)
                         | (op_kind == ceil_pkg::CEIL_OP_CLEAN);
  assign maint           = (op_kind == ceil_pkg::CEIL_OP_CLEAN)
                         | (op_kind == ceil_pkg::CEIL_OP_INVAL);
  assign fill_err        = nl_fill_vld & (nl_fill_resp[1]);
  assign wresp_err       = nl_bresp_vld & (nl_bresp[1]);

  // ----------------------------------------------------------------
  // interrupt set terms
  // ----------------------------------------------------------------
  // every transaction kind raises the same lines for the same fault;
  // only the side effects below differ per kind
  always_comb
  begin
    irq_set = ceil_pkg::IRQ_RST;
    irq_set[ceil_pkg::IRQ_TRDERR] = tag_rd_ram_err;
    irq_set[ceil_pkg::IRQ_TRDPAR] = tag_rd_par_err;
    irq_set[ceil_pkg::IRQ_DRDERR] = data_rd_ram_err;
    irq_set[ceil_pkg::IRQ_DRDPAR] = data_rd_par_err;
    irq_set[ceil_pkg::IRQ_DWRERR] = data_wr_ram_err;
    irq_set[ceil_pkg::IRQ_TWRERR] = tag_wr_ram_err;
    irq_set[ceil_pkg::IRQ_DECERR] = (wresp_err & (nl_bresp == ceil_pkg::RESP_DEC))
      | (fill_err & (nl_fill_resp == ceil_pkg::RESP_DEC));
    irq_set[ceil_pkg::IRQ_SLVERR] = (wresp_err & (nl_bresp == ceil_pkg::RESP_SLV))
      | (fill_err & (nl_fill_resp == ceil_pkg::RESP_SLV));
    irq_set[ceil_pkg::IRQ_ECNT]   = evt_cnt_overflow
                                  | (evt_cnt_irq_on_inc & evt_cnt_increment);
  end

  // ----------------------------------------------------------------
  // sticky lines
  // ----------------------------------------------------------------
  // set wins over a clear in the same cycle so no event is lost
  assign next_irq = irq_set | (irq & ~irq_clear);
  assign set_and_clear = irq_set & irq_clear;

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      irq <= ceil_pkg::IRQ_RST;
    else if (clk_en)
      irq <= next_irq;
  end

  // combined line registered from next value so it tracks the lines exactly
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      combined_irq <= 1'b0;
    else if (clk_en)
      combined_irq <= |next_irq;
  end

  assign next_level_decode_err_irq = irq[ceil_pkg::IRQ_DECERR];
  assign next_level_slave_err_irq  = irq[ceil_pkg::IRQ_SLVERR];
  assign data_ram_read_err_irq     = irq[ceil_pkg::IRQ_DRDERR];
  assign tag_ram_read_err_irq      = irq[ceil_pkg::IRQ_TRDERR];
  assign data_ram_write_err_irq    = irq[ceil_pkg::IRQ_DWRERR];
  assign tag_ram_write_err_irq     = irq[ceil_pkg::IRQ_TWRERR];
  assign data_read_parity_irq      = irq[ceil_pkg::IRQ_DRDPAR];
  assign tag_read_parity_irq       = irq[ceil_pkg::IRQ_TRDPAR];
  assign event_counter_irq         = irq[ceil_pkg::IRQ_ECNT];

  // ----------------------------------------------------------------
  // write parity
  // ----------------------------------------------------------------
  genvar gb;
  generate
    for (gb = 0; gb < ceil_pkg::DATA_BYTES; gb++)
    begin : g_byte_par
      always_ff @(posedge sys_clk or negedge arst_n)
      begin
        if (!arst_n)
          data_wr_parity[gb] <= 1'b0;
        else if (clk_en)
          data_wr_parity[gb] <= ^data_wr_data[gb*8 +: 8];
      end
    end
  endgenerate

  // one bit suffices: only a single tag way is written per cycle
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      tag_wr_parity <= 1'b0;
    else if (clk_en)
      tag_wr_parity <= ^tag_wr_data;
  end

  // ----------------------------------------------------------------
  // side effects per transaction kind
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      slave_read_response_err <= 1'b0;
      slave_read_response     <= ceil_pkg::RESP_OK;
    end
    else if (clk_en)
    begin
      slave_read_response_err <= slave_rd & (tag_rd_any | data_rd_ram_err
                                             | data_rd_par_err);
      slave_read_response     <= (slave_rd & (tag_rd_any | data_rd_ram_err | data_rd_par_err))
                               ? ceil_pkg::RESP_SLV : ceil_pkg::RESP_OK;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      cache_write_block <= 1'b0;
    else if (clk_en)
      cache_write_block <= (op_kind == ceil_pkg::CEIL_OP_STORE_BUF) & tag_rd_any;
  end

  // parity errors on eviction data pass; only a data RAM fault or an allocation tag read error masks the write
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      evict_mask <= 1'b0;
    else if (clk_en)
      evict_mask <= ((op_kind == ceil_pkg::CEIL_OP_ALLOC) & tag_rd_any)
                  | (evicting & data_rd_ram_err);
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      maint_cancel <= 1'b0;
    else if (clk_en)
      maint_cancel <= maint & tag_rd_any;
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      fill_discard <= 1'b0;
    else if (clk_en)
      fill_discard <= fill_err;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_STICKY: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (clk_en && $past(clk_en) && $past(irq) != 9'h000 && $past(irq_clear) == 9'h000)
      |-> ((irq & $past(irq)) == $past(irq)))
    else $error("sticky line dropped without clear");

  AST_COMBINED: assert property (@(posedge sys_clk) disable iff (!arst_n)
    combined_irq == (|irq))
    else $error("combined line differs from OR of lines");

  AST_ECNT: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (clk_en && evt_cnt_overflow) |=> event_counter_irq)
    else $error("counter overflow not reported");

  AST_DPAR: assert property (@(posedge sys_clk) disable iff (!arst_n)
    clk_en |=> (data_wr_parity[0] == ^($past(data_wr_data[7:0]))))
    else $error("byte parity wrong");

  AST_TPAR: assert property (@(posedge sys_clk) disable iff (!arst_n)
    clk_en |=> (tag_wr_parity == ^($past(tag_wr_data))))
    else $error("tag parity wrong");

  AST_SLVERR: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (clk_en && slave_rd && tag_rd_ram_err)
      |=> (slave_read_response == 2'h2 && tag_ram_read_err_irq))
    else $error("slave read tag fault not reported");

  AST_NOWRITE: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (clk_en && op_kind == ceil_pkg::CEIL_OP_STORE_BUF && tag_rd_par_err)
      |=> (cache_write_block && tag_read_parity_irq))
    else $error("store buffer write not blocked");

  AST_PARPASS: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (clk_en && evicting && data_rd_par_err
       && !data_rd_ram_err && !tag_rd_any) |=> !evict_mask)
    else $error("parity error wrongly masked eviction");

  AST_CANCEL: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (clk_en && op_kind == ceil_pkg::CEIL_OP_INVAL && tag_rd_any) |=> maint_cancel)
    else $error("invalidate not cancelled");

  AST_TWR: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (clk_en && tag_wr_ram_err) |=> tag_ram_write_err_irq)
    else $error("tag write fault not reported");

  AST_FILL: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (clk_en && fill_err) |=> (fill_discard && (next_level_slave_err_irq
                                              || next_level_decode_err_irq)))
    else $error("linefill error not handled");

  AST_SETWINS: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (clk_en && set_and_clear != 9'h000)
      |=> ((irq & $past(set_and_clear)) == $past(set_and_clear)))
    else $error("clear beat a set");

  AST_RDDATA: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (clk_en && slave_rd && data_rd_ram_err)
      |=> (slave_read_response == ceil_pkg::RESP_SLV && data_ram_read_err_irq))
    else $error("slave read data fault not reported");

  AST_EVTAG: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (clk_en && op_kind == ceil_pkg::CEIL_OP_ALLOC && tag_rd_any)
      |=> (evict_mask && !maint_cancel))
    else $error("eviction tag fault not masked");

  AST_CLCANCEL: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (clk_en && op_kind == ceil_pkg::CEIL_OP_CLEAN && tag_rd_any) |=> maint_cancel)
    else $error("clean not cancelled");

  AST_WRESP: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (clk_en && wresp_err && !slave_rd && !fill_err)
      |=> (!slave_read_response_err && !fill_discard
           && (next_level_slave_err_irq || next_level_decode_err_irq)))
    else $error("write response error misreported");

  COV_EVT_INC: cover property (@(posedge sys_clk) disable iff (!arst_n)
    clk_en && evt_cnt_irq_on_inc && evt_cnt_increment ##1 event_counter_irq);

  COV_ALLOC_MASK: cover property (@(posedge sys_clk) disable iff (!arst_n)
    clk_en && op_kind == ceil_pkg::CEIL_OP_ALLOC && tag_rd_any ##1 evict_mask);
  COV_MULTI: cover property (@(posedge sys_clk) disable iff (!arst_n)
    $countones(irq_set) > 1 && clk_en);
  COV_CLEAR: cover property (@(posedge sys_clk) disable iff (!arst_n)
    combined_irq ##1 !combined_irq);

endmodule

`default_nettype wire

// >>> src/ceil_pkg.sv
// ceil_pkg: constants shared by the cache error and interrupt logic.
// assumes a single controller clock; no software-visible registers here.
package ceil_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned DATA_BYTES = 32;
  localparam int unsigned DATA_W     = DATA_BYTES * 8;
  localparam int unsigned TAG_W      = 21;
  localparam int unsigned TAG_WAYS   = 8;
  localparam int unsigned IRQ_NUM    = 9;

  // ----------------------------------------------------------------
  // interrupt line positions in the sticky vector
  // ----------------------------------------------------------------
  localparam int unsigned IRQ_DECERR = 0;
  localparam int unsigned IRQ_SLVERR = 1;
  localparam int unsigned IRQ_DRDERR = 2;
  localparam int unsigned IRQ_TRDERR = 3;
  localparam int unsigned IRQ_DWRERR = 4;
  localparam int unsigned IRQ_TWRERR = 5;
  localparam int unsigned IRQ_DRDPAR = 6;
  localparam int unsigned IRQ_TRDPAR = 7;
  localparam int unsigned IRQ_ECNT   = 8;

  // ----------------------------------------------------------------
  // reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [IRQ_NUM-1:0] IRQ_RST  = 9'h000;
  localparam logic [1:0]         RESP_OK  = 2'h0;
  localparam logic [1:0]         RESP_SLV = 2'h2;
  localparam logic [1:0]         RESP_DEC = 2'h3;

  // transaction that owns the current RAM access
  typedef enum logic [2:0]
  {
    CEIL_OP_NONE,
    CEIL_OP_SLAVE_READ,
    CEIL_OP_STORE_BUF,
    CEIL_OP_ALLOC,
    CEIL_OP_CLEAN,
    CEIL_OP_INVAL
  } ceil_op_t;

endpackage

// >>> verification/ceil_irq_host.sv
// ceil_irq_host: far-side model, interrupt controller plus tag RAM parity fan-out.
// assumes the bench raises svc_go mid-cycle when software services the lines.
`timescale 1ns/1ns
`default_nettype none

module ceil_irq_host
(
  // sticky lines and tag parity from the block
  input  wire logic [ceil_pkg::IRQ_NUM-1:0]  irq_lines,
  input  wire logic                          tag_wr_parity,
  // service request from the bench
  input  wire logic                          svc_go,
  input  wire logic [ceil_pkg::IRQ_NUM-1:0]  svc_mask,
  // clear pulses and per-way tag parity
  output logic      [ceil_pkg::IRQ_NUM-1:0]  irq_clear,
  output logic      [ceil_pkg::TAG_WAYS-1:0] tag_parity_ways
);
  // clears only lines it saw high, as software does after reading status
  assign irq_clear = svc_go ? (irq_lines & svc_mask) : 9'h000;
  // one bit feeds every way: only one way is written at a time
  assign tag_parity_ways = {ceil_pkg::TAG_WAYS{tag_wr_parity}};
endmodule

`default_nettype wire

// >>> verification/tb_top.sv
// tb_top: scoreboard bench for the cache error and interrupt logic.
// assumes registered outputs one cycle after each enabled edge.
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  localparam ceil_pkg::ceil_op_t NO = ceil_pkg::CEIL_OP_NONE;
  localparam ceil_pkg::ceil_op_t SR = ceil_pkg::CEIL_OP_SLAVE_READ;
  localparam ceil_pkg::ceil_op_t SB = ceil_pkg::CEIL_OP_STORE_BUF;
  localparam ceil_pkg::ceil_op_t AL = ceil_pkg::CEIL_OP_ALLOC;
  localparam ceil_pkg::ceil_op_t CL = ceil_pkg::CEIL_OP_CLEAN;
  localparam ceil_pkg::ceil_op_t IV = ceil_pkg::CEIL_OP_INVAL;
  localparam logic [13:0] TRV = 14'h0001, TPE = 14'h0002, DRV = 14'h0004, DPE = 14'h0008;
  localparam logic [13:0] DF = 14'h0010, TWV = 14'h0020, DWV = 14'h0040, BRV = 14'h0080;
  localparam logic [13:0] FV = 14'h0100, OV = 14'h0200, INC = 14'h0400, ONI = 14'h0800;
  localparam logic [13:0] FRZ = 14'h1000, SVC = 14'h2000;
  localparam int LIMIT = 2000;

  logic sys_clk = 1'b0, arst_n, clk_en, frz, svc_go;
  ceil_pkg::ceil_op_t op_kind;
  logic tag_rd_vld, tag_rd_parity_err, tag_wr_vld, data_rd_vld, data_rd_parity_err;
  logic data_wr_vld, data_array_fault_in, nl_bresp_vld, nl_fill_vld;
  logic evt_cnt_overflow, evt_cnt_increment, evt_cnt_irq_on_inc;
  logic [7:0] tag_array_fault_in, tag_parity_ways;
  logic [20:0] tag_wr_data;
  logic [255:0] data_wr_data;
  logic [1:0] nl_bresp, nl_fill_resp, slave_read_response;
  logic [8:0] irq_clear, svc_mask, irq_lines, exp_lines;
  logic [31:0] data_wr_parity, seed;
  logic tag_wr_parity, slave_read_response_err, cache_write_block, evict_mask;
  logic maint_cancel, fill_discard, combined_irq;
  logic next_level_decode_err_irq, next_level_slave_err_irq, data_ram_read_err_irq;
  logic tag_ram_read_err_irq, data_ram_write_err_irq, tag_ram_write_err_irq;
  logic data_read_parity_irq, tag_read_parity_irq, event_counter_irq;
  logic [6:0] steer;
  logic [49:0] e, exp_prev;
  logic [49:0] exp_q[$];
  int err_count = 0, n_compared = 0, cyc = 0;

  assign irq_lines = {event_counter_irq, tag_read_parity_irq, data_read_parity_irq,
                      tag_ram_write_err_irq, data_ram_write_err_irq, tag_ram_read_err_irq,
                      data_ram_read_err_irq, next_level_slave_err_irq, next_level_decode_err_irq};
  assign steer = {slave_read_response, slave_read_response_err, cache_write_block,
                  evict_mask, maint_cancel, fill_discard};

  ceil_core u_ceil_core (.sys_clk, .arst_n, .clk_en, .op_kind, .tag_rd_vld, .tag_rd_parity_err,
    .tag_wr_vld, .tag_array_fault_in, .tag_wr_data, .data_rd_vld, .data_rd_parity_err,
    .data_wr_vld, .data_array_fault_in, .data_wr_data, .nl_bresp_vld, .nl_bresp, .nl_fill_vld,
    .nl_fill_resp, .evt_cnt_overflow, .evt_cnt_increment, .evt_cnt_irq_on_inc, .irq_clear,
    .data_wr_parity, .tag_wr_parity, .slave_read_response_err, .slave_read_response,
    .cache_write_block, .evict_mask, .maint_cancel, .fill_discard, .next_level_decode_err_irq,
    .next_level_slave_err_irq, .data_ram_read_err_irq, .tag_ram_read_err_irq,
    .data_ram_write_err_irq, .tag_ram_write_err_irq, .data_read_parity_irq,
    .tag_read_parity_irq, .event_counter_irq, .combined_irq);

  ceil_irq_host u_ceil_irq_host (.irq_lines, .tag_wr_parity, .svc_go, .svc_mask, .irq_clear,
    .tag_parity_ways);

  always #4 sys_clk = ~sys_clk;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // driver: applies one cycle of inputs and notes the expected outputs
  // ----------------------------------------------------------------
  task automatic go(input ceil_pkg::ceil_op_t op, input logic [7:0] tf, input logic [13:0] f,
                    input logic [1:0] br, input logic [1:0] fr, input logic [8:0] mask);
    logic [8:0] s;
    logic [4:0] p;
    logic [31:0] dp;
    logic tre;
    op_kind = op;
    tag_array_fault_in = tf;
    nl_bresp = br;
    nl_fill_resp = fr;
    svc_mask = mask;
    {svc_go, frz, evt_cnt_irq_on_inc, evt_cnt_increment, evt_cnt_overflow, nl_fill_vld,
     nl_bresp_vld, data_wr_vld, tag_wr_vld, data_array_fault_in, data_rd_parity_err,
     data_rd_vld, tag_rd_parity_err, tag_rd_vld} = f;
    clk_en = ~frz;
    for (int i = 0; i < 8; i++)
    begin
      seed = lfsr(seed);
      data_wr_data[32*i +: 32] = seed;
    end
    tag_wr_data = seed[20:0];
    for (int i = 0; i < ceil_pkg::DATA_BYTES; i++)
      dp[i] = ^data_wr_data[8*i +: 8];
    tre = tag_rd_vld & (tag_rd_parity_err | (|tf));
    s = 9'h000;
    if (op != NO)
    begin
      s[ceil_pkg::IRQ_TRDPAR] = tag_rd_vld & tag_rd_parity_err;
      s[ceil_pkg::IRQ_TRDERR] = tag_rd_vld & (|tf);
    end
    if (op == SR || op == AL || op == CL)
    begin
      s[ceil_pkg::IRQ_DRDPAR] = data_rd_vld & data_rd_parity_err;
      s[ceil_pkg::IRQ_DRDERR] = data_rd_vld & data_array_fault_in;
    end
    s[ceil_pkg::IRQ_TWRERR] = tag_wr_vld && (|tf) && (op == AL || op == IV);
    s[ceil_pkg::IRQ_DWRERR] = data_wr_vld && data_array_fault_in && (op == SB || op == AL);
    s[ceil_pkg::IRQ_SLVERR] = (nl_bresp_vld && br == 2'h2) || (nl_fill_vld && fr == 2'h2);
    s[ceil_pkg::IRQ_DECERR] = (nl_bresp_vld && br == 2'h3) || (nl_fill_vld && fr == 2'h3);
    s[ceil_pkg::IRQ_ECNT] = evt_cnt_overflow | (evt_cnt_increment & evt_cnt_irq_on_inc);
    p = {op == SR && (tre || (data_rd_vld && (data_rd_parity_err || data_array_fault_in))),
         op == SB && tre,
         (op == AL && tre) || ((op == AL || op == CL) && data_rd_vld && data_array_fault_in),
         (op == CL || op == IV) && tre,
         nl_fill_vld && fr[1]};
    if (!frz)
    begin
      exp_lines = (svc_go ? (exp_lines & ~mask) : exp_lines) | s;
      exp_prev = {exp_lines, |exp_lines, p[4] ? ceil_pkg::RESP_SLV : ceil_pkg::RESP_OK, p,
                  ^tag_wr_data, dp};
    end
    exp_q.push_back(exp_prev);
    @(negedge sys_clk);
  endtask

  // ----------------------------------------------------------------
  // monitor: settled outputs two ns after each edge
  // ----------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    #2;
    if (exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      chk("irq_lines", 64'(irq_lines), 64'(e[49:41]));
      chk("combined", 64'(combined_irq), 64'(e[40]));
      chk("steering", 64'(steer), 64'(e[39:33]));
      chk("parity", 64'({tag_wr_parity, data_wr_parity}), 64'(e[32:0]));
      chk("tag_ways", 64'(tag_parity_ways), 64'({8{e[32]}}));
    end
  end

  // hang guard, far above the few dozen cycles the sequence needs
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      err_count++;
      close_out();
    end
  end

  initial
  begin
    seed = 32'h0000003C;
    exp_lines = 9'h000;
    exp_prev = '0;
    arst_n = 1'b0;
    clk_en = 1'b1;
    op_kind = NO;
    {svc_go, frz, evt_cnt_irq_on_inc, evt_cnt_increment, evt_cnt_overflow, nl_fill_vld,
     nl_bresp_vld, data_wr_vld, tag_wr_vld, data_array_fault_in, data_rd_parity_err,
     data_rd_vld, tag_rd_parity_err, tag_rd_vld} = 14'h0000;
    {tag_array_fault_in, tag_wr_data, data_wr_data, nl_bresp, nl_fill_resp, svc_mask} = '0;
    repeat (5) @(negedge sys_clk);
    arst_n = 1'b1;
    go(SR, 8'h00, TRV | DRV, 2'h0, 2'h0, 9'h000);
    for (int w = 0; w < 8; w++)
      go(SR, 8'h01 << w, TRV, 2'h0, 2'h0, 9'h000);
    go(SR, 8'h00, TRV | TPE, 2'h0, 2'h0, 9'h000);
    go(SR, 8'h00, DRV | DF, 2'h0, 2'h0, 9'h000);
    go(SR, 8'h00, DRV | DPE, 2'h0, 2'h0, 9'h000);
    go(NO, 8'h00, SVC, 2'h0, 2'h0, 9'h1FF);
    go(SB, 8'h80, TRV | TPE, 2'h0, 2'h0, 9'h000);
    go(SB, 8'h00, DWV | DF, 2'h0, 2'h0, 9'h000);
    go(AL, 8'h00, TRV | TPE, 2'h0, 2'h0, 9'h000);
    go(AL, 8'h00, DRV | DF, 2'h0, 2'h0, 9'h000);
    go(AL, 8'h00, DRV | DPE, 2'h0, 2'h0, 9'h000);
    go(AL, 8'h08, TWV, 2'h0, 2'h0, 9'h000);
    go(AL, 8'h00, DWV | DF, 2'h0, 2'h0, 9'h000);
    go(CL, 8'h02, TRV | SVC, 2'h0, 2'h0, 9'h1FF);
    go(CL, 8'h00, DRV | DF, 2'h0, 2'h0, 9'h000);
    go(CL, 8'h00, DRV | DPE, 2'h0, 2'h0, 9'h000);
    go(IV, 8'h00, TRV | TPE, 2'h0, 2'h0, 9'h000);
    go(IV, 8'h40, TWV, 2'h0, 2'h0, 9'h000);
    go(NO, 8'h00, SVC, 2'h0, 2'h0, 9'h1FF);
    go(NO, 8'h00, BRV | OV, 2'h2, 2'h0, 9'h000);
    go(NO, 8'h00, BRV, 2'h3, 2'h0, 9'h000);
    go(NO, 8'h00, BRV, 2'h1, 2'h0, 9'h000);
    go(NO, 8'h00, SVC, 2'h0, 2'h0, 9'h100);
    go(NO, 8'h00, INC, 2'h0, 2'h0, 9'h000);
    go(NO, 8'h00, INC | ONI, 2'h0, 2'h0, 9'h000);
    go(SR, 8'h01, TRV | FRZ, 2'h0, 2'h0, 9'h000);
    arst_n = 1'b0;
    @(negedge sys_clk);
    chk("reset", 64'({irq_lines, combined_irq, steer}), 64'h0);
    arst_n = 1'b1;
    exp_lines = 9'h000;
    exp_prev = '0;
    go(NO, 8'h00, FV, 2'h0, 2'h2, 9'h000);
    go(NO, 8'h00, FV, 2'h0, 2'h3, 9'h000);
    go(NO, 8'h00, FV, 2'h0, 2'h1, 9'h000);
    go(NO, 8'h00, SVC, 2'h0, 2'h0, 9'h1FF);
    go(NO, 8'h00, 14'h0000, 2'h0, 2'h0, 9'h000);
    @(negedge sys_clk);
    close_out();
  end
endmodule

`default_nettype wire
